// [rtl/mmd_top.sv]
// memory map decoder top: program fetch block switching, reset loading
// of the switch field, data space decode and the external bus cycle.
// assumes synchronous core requests and an AXI4-Lite master for registers.
// Operation
// - switch 1x hides secondary block from fetch
// - switch 01 maps primary low, secondary high
// - switch 00 fetches low 8K from secondary
// - overlay leaves rest on primary, low via programming
// - every reset loads bit 0 from start-up bit 0
// - software may change bit 0 only
// - power-on load follows both start-up bits
// - watchdog, brown-out, software reset partial loads
// - start-up bit reads 0 when programmed
// - 1024 internal RAM bytes, 64KB external space
// - low 128 bytes direct and indirect alike
// - upper half: indirect RAM, direct SFR
// - external moves below 300H hit expanded RAM
// - byte pointer or data pointer addressing allowed
// - expanded RAM access leaves bus pins still
// - external moves from 300H run bus cycle
// - disabled expanded RAM: byte pointer 8-bit address
// - 6-clock mode strobe at one third rate
`timescale 1ns/1ps
module mmd_top
  import mmd_pkg::*;
#(
  parameter int unsigned ADDR_W = 4,
  parameter int unsigned RAM_W = $clog2(RAM_BYTES)
) (
  input logic core_clk_i,
  input logic rstn_i,
  input logic startup_cfg_bit0_i,
  input logic startup_cfg_bit1_i,
  input logic rst_evt_i,
  input mmd_rst_e rst_kind_i,
  input logic fetch_req_i,
  input logic [EXT_AW-1:0] fetch_addr_i,
  output logic fetch_vld_o,
  output mmd_fsel_e fetch_sel_o,
  output logic [EXT_AW-1:0] fetch_off_o,
  input logic iap_req_i,
  input logic [EXT_AW-1:0] iap_addr_i,
  output logic iap_vld_o,
  output mmd_fsel_e iap_sel_o,
  output logic [EXT_AW-1:0] iap_off_o,
  input logic dacc_req_i,
  input mmd_dkind_e dacc_kind_i,
  input logic [EXT_AW-1:0] dacc_addr_i,
  input logic dacc_we_i,
  input logic [7:0] dacc_wdata_i,
  output logic dacc_ready_o,
  output logic dacc_hit_o,
  output mmd_dtgt_e dacc_tgt_o,
  output logic [RAM_W-1:0] dacc_idx_o,
  output logic ext_done_o,
  output logic [7:0] ext_rdata_o,
  input logic [7:0] p0_i,
  output logic [7:0] p0_o,
  output logic p0_oe_o,
  output logic [7:0] p2_o,
  output logic p2_oe_o,
  output logic ale_o,
  output logic wr_n_o,
  output logic rd_n_o,
  input logic [ADDR_W-1:0] s_axi_awaddr_i,
  input logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input logic [31:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  input logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  input logic [ADDR_W-1:0] s_axi_araddr_i,
  input logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input logic s_axi_rready_i
);
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  // fetch map for the current switch setting
  function automatic mmd_fsel_e map_fetch(input logic [15:0] a, input logic [1:0] m);
    if (m == BSW_OVERLAY && a <= OVL_TOP) return F_SEC;
    if (a <= PRI_TOP) return F_PRI;
    if (m == BSW_BOTH && a >= SEC_BASE) return F_SEC;
    return F_EXT;
  endfunction : map_fetch

  // offset inside the chosen block; secondary is 8K either way
  function automatic logic [15:0] blk_off(input mmd_fsel_e s, input logic [15:0] a);
    return (s == F_SEC) ? {3'b000, a[12:0]} : a;
  endfunction : blk_off

  // register decode shared by read and write
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [3:0] w;
    w = {a[3:2], 2'b00};
    return (w == OFS_BSW) || (w == OFS_AUX) || (w == OFS_STAT);
  endfunction : is_mapped

  logic [1:0] bsw_q;
  logic [1:0] aux_q;
  logic load_por_q;
  mmd_rst_e last_rst_q;
  mmd_rst_e rc_kind;
  logic [1:0] rc_bsw;
  logic rc_load;
  logic aw_q;
  logic w_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_en;
  logic wr_bsw;
  logic wr_aux;
  mmd_fsel_e fsel_d;
  mmd_fsel_e isel_d;
  logic fetch_vld_q;
  mmd_fsel_e fetch_sel_q;
  logic [15:0] fetch_off_q;
  logic iap_vld_q;
  mmd_fsel_e iap_sel_q;
  logic [15:0] iap_off_q;
  logic [2:0] ale_cnt_q;
  logic [2:0] ale_last;
  logic ale_tick;
  mmd_ext_e ext_st_q;
  logic [2:0] strb_cnt_q;
  logic ext_we_q;
  logic [7:0] ext_wdata_q;
  logic dacc_take;
  logic ext_start;
  logic dacc_hit_q;
  mmd_dtgt_e dacc_tgt_q;
  logic [RAM_W-1:0] dacc_idx_q;
  logic ext_done_q;
  logic [7:0] ext_rdata_q;
  logic [7:0] p0_q;
  logic p0_oe_q;
  logic [7:0] p2_q;
  logic p2_oe_q;
  logic ale_q;
  logic wr_n_q;
  logic rd_n_q;

  mmd_dacc_if dd ();

  // reset load value, power-on kind right after rstn release
  assign rc_kind = load_por_q ? RST_POR : rst_kind_i;
  assign rc_load = load_por_q | rst_evt_i;

  mmd_reset_cfg u_rst_cfg (
    .kind_i(rc_kind),
    .sc1_i(startup_cfg_bit1_i),
    .sc0_i(startup_cfg_bit0_i),
    .cur_i(bsw_q),
    .bsw_o(rc_bsw)
  );

  assign dd.kind = dacc_kind_i;
  assign dd.addr = dacc_addr_i;
  assign dd.xram_dis = aux_q[AUX_XRAM_DIS];

  mmd_data_decode u_dec (
    .d(dd)
  );

  // write channel: address and data taken in either order
  assign s_axi_awready_o = !aw_q && !bvalid_q;
  assign s_axi_wready_o = !w_q && !bvalid_q;
  assign wr_en = aw_q && w_q;
  assign wr_bsw = wr_en && wstrb_q[0] && ({awaddr_q[3:2], 2'b00} == OFS_BSW);
  assign wr_aux = wr_en && wstrb_q[0] && ({awaddr_q[3:2], 2'b00} == OFS_AUX);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OK;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_en) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q) ? RESP_OK : RESP_ERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel, one word per request
  assign s_axi_arready_o = !rvalid_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OK;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_q <= 1'b1;
      rresp_q <= is_mapped(s_axi_araddr_i) ? RESP_OK : RESP_ERR;
      case ({s_axi_araddr_i[3:2], 2'b00})
        OFS_BSW: rdata_q <= {30'h0000_0000, bsw_q};
        OFS_AUX: rdata_q <= {30'h0000_0000, aux_q};
        OFS_STAT: rdata_q <= {28'h000_0000, last_rst_q, startup_cfg_bit1_i,
                              startup_cfg_bit0_i};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // block switch field; a reset load wins over a software write
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bsw_q <= BSW_RST;
      load_por_q <= 1'b1;
      last_rst_q <= RST_POR;
    end else begin
      load_por_q <= 1'b0;
      if (rc_load) begin
        bsw_q <= rc_bsw;
        last_rst_q <= rc_kind;
      end else if (wr_bsw) begin
        bsw_q[0] <= wdata_q[0];
      end
    end
  end

  // auxiliary control: expanded RAM disable and 6-clock mode
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aux_q <= AUX_RST;
    end else if (wr_aux) begin
      aux_q <= wdata_q[1:0];
    end
  end

  // fetch mapping sampled with the field as it stood at the request
  assign fsel_d = map_fetch(fetch_addr_i, bsw_q);
  assign isel_d = (iap_addr_i <= PRI_TOP) ? F_PRI :
                  (iap_addr_i >= SEC_BASE) ? F_SEC : F_NONE;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fetch_vld_q <= 1'b0;
      fetch_sel_q <= F_NONE;
      fetch_off_q <= 16'h0000;
    end else begin
      fetch_vld_q <= fetch_req_i;
      if (fetch_req_i) begin
        fetch_sel_q <= fsel_d;
        fetch_off_q <= blk_off(fsel_d, fetch_addr_i);
      end
    end
  end

  // programming path sees both blocks whatever the switch
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      iap_vld_q <= 1'b0;
      iap_sel_q <= F_NONE;
      iap_off_q <= 16'h0000;
    end else begin
      iap_vld_q <= iap_req_i;
      if (iap_req_i) begin
        iap_sel_q <= isel_d;
        iap_off_q <= blk_off(isel_d, iap_addr_i);
      end
    end
  end

  // address strobe divider; free running while the bus is idle
  assign ale_last = aux_q[AUX_SIXCLK] ? 3'(ALE_DIV_6CLK - 1) : 3'(ALE_DIV_12CLK - 1);
  assign ale_tick = (ale_cnt_q == 3'h0);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ale_cnt_q <= 3'h0;
    end else if (ale_cnt_q >= ale_last) begin
      ale_cnt_q <= 3'h0;
    end else begin
      ale_cnt_q <= ale_cnt_q + 3'h1;
    end
  end

  // data access acceptance; core must wait while a bus cycle runs
  assign dacc_ready_o = (ext_st_q == EX_IDLE);
  assign dacc_take = dacc_req_i && dacc_ready_o;
  assign ext_start = dacc_take && (dd.tgt == D_EXT);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dacc_hit_q <= 1'b0;
      dacc_tgt_q <= D_NONE;
      dacc_idx_q <= '0;
    end else begin
      dacc_hit_q <= dacc_take && (dd.tgt != D_EXT);
      if (dacc_take) begin
        dacc_tgt_q <= dd.tgt;
        dacc_idx_q <= dd.idx[RAM_W-1:0];
      end
    end
  end

  // external bus cycle: address phase then strobe phase
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_st_q <= EX_IDLE;
      strb_cnt_q <= 3'h0;
      ext_we_q <= 1'b0;
      ext_wdata_q <= 8'h00;
      ext_done_q <= 1'b0;
      ext_rdata_q <= 8'h00;
      p0_q <= 8'h00;
      p0_oe_q <= 1'b0;
      p2_q <= 8'h00;
      p2_oe_q <= 1'b0;
      ale_q <= 1'b0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      ext_done_q <= 1'b0;
      case (ext_st_q)
        EX_IDLE: begin
          // only a true external target touches the pins
          if (ext_start) begin
            ext_st_q <= EX_ADDR;
            ext_we_q <= dacc_we_i;
            ext_wdata_q <= dacc_wdata_i;
            p0_q <= dacc_addr_i[7:0];
            p0_oe_q <= 1'b1;
            p2_q <= dacc_addr_i[15:8];
            p2_oe_q <= dd.hi_drive;
            ale_q <= 1'b1;
          end else begin
            ale_q <= ale_tick;
          end
        end
        EX_ADDR: begin
          ext_st_q <= EX_STRB;
          strb_cnt_q <= 3'(STROBE_CYC - 1);
          ale_q <= 1'b0;
          p0_q <= ext_wdata_q;
          p0_oe_q <= ext_we_q;
          wr_n_q <= !ext_we_q;
          rd_n_q <= ext_we_q;
        end
        EX_STRB: begin
          if (strb_cnt_q == 3'h0) begin
            ext_st_q <= EX_IDLE;
            ext_done_q <= 1'b1;
            ext_rdata_q <= ext_we_q ? ext_rdata_q : p0_i;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            p0_oe_q <= 1'b0;
            p2_oe_q <= 1'b0;
          end else begin
            strb_cnt_q <= strb_cnt_q - 3'h1;
          end
        end
        default: ext_st_q <= EX_IDLE;
      endcase
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign fetch_vld_o = fetch_vld_q;
  assign fetch_sel_o = fetch_sel_q;
  assign fetch_off_o = fetch_off_q;
  assign iap_vld_o = iap_vld_q;
  assign iap_sel_o = iap_sel_q;
  assign iap_off_o = iap_off_q;
  assign dacc_hit_o = dacc_hit_q;
  assign dacc_tgt_o = dacc_tgt_q;
  assign dacc_idx_o = dacc_idx_q;
  assign ext_done_o = ext_done_q;
  assign ext_rdata_o = ext_rdata_q;
  assign p0_o = p0_q;
  assign p0_oe_o = p0_oe_q;
  assign p2_o = p2_q;
  assign p2_oe_o = p2_oe_q;
  assign ale_o = ale_q;
  assign wr_n_o = wr_n_q;
  assign rd_n_o = rd_n_q;

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_ext_go;
    ext_start && !dacc_we_i;
  endsequence
  sequence s_rd_strobe;
    ale_o ##1 (!rd_n_o && wr_n_o)[*3] ##1 ext_done_o;
  endsequence

  a_por_load: assert property (load_por_q |=>
    bsw_q == {~$past(startup_cfg_bit1_i), ~$past(startup_cfg_bit0_i)})
    else $error("power-on load of switch field wrong");
  a_sw_reset: assert property (rst_evt_i && !load_por_q && rst_kind_i == RST_SW
    |=> bsw_q == {1'b1, ~$past(startup_cfg_bit0_i)})
    else $error("software reset load wrong");
  a_bit1_kept: assert property (wr_bsw && !rc_load |=>
    bsw_q[1] == $past(bsw_q[1]) && bsw_q[0] == $past(wdata_q[0]))
    else $error("switch write touched bit 1 or missed bit 0");
  a_overlay_fetch: assert property (fetch_req_i && bsw_q == BSW_OVERLAY
    && fetch_addr_i <= OVL_TOP |=> fetch_sel_o == F_SEC)
    else $error("overlay fetch not from secondary");
  a_hidden_sec: assert property (fetch_req_i && bsw_q[1] |=> fetch_sel_o != F_SEC)
    else $error("secondary block visible to fetch");
  a_both_vis: assert property (fetch_req_i && bsw_q == BSW_BOTH
    && fetch_addr_i >= SEC_BASE |=> fetch_sel_o == F_SEC)
    else $error("secondary not at top in mode 01");
  a_low_ram: assert property (dacc_take && dacc_kind_i inside {K_DIR, K_IND}
    && dacc_addr_i[7:0] <= LOW_TOP |=> dacc_hit_o && dacc_tgt_o == D_LOW
    && dacc_idx_o == RAM_W'($past(dacc_addr_i[7:0])))
    else $error("low RAM decode wrong");
  a_upper_split: assert property (dacc_take && dacc_addr_i[7:0] > LOW_TOP
    && dacc_kind_i == K_DIR |=> dacc_tgt_o == D_SFR)
    else $error("direct upper access not to SFR");
  a_xram_quiet: assert property (dacc_take && dd.tgt == D_XRAM
    |=> (wr_n_o && rd_n_o && !p0_oe_o && !p2_oe_o)[*2])
    else $error("bus pins moved on expanded RAM access");
  a_ext_read: assert property (s_ext_go |=> s_rd_strobe)
    else $error("external read cycle malformed");
  a_ri_page: assert property (ext_start && dacc_kind_i == K_XRI |=> !p2_oe_o)
    else $error("byte pointer move drove port 2");
  a_ale_third: assert property ((aux_q[AUX_SIXCLK] && ale_tick) ##1
    aux_q[AUX_SIXCLK][*2] |=> ale_tick)
    else $error("six clock strobe rate not one third");
endmodule : mmd_top

// [rtl/mmd_pkg.sv]
// shared constants and types of the memory map decoder
// assumes one 100 MHz core clock domain and a 32-bit register bus
package mmd_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // address strobe divide ratios, in core clocks
  localparam int unsigned ALE_DIV_6CLK = 3;
  localparam int unsigned ALE_DIV_12CLK = 6;
  // least low time of the external read/write strobes
  localparam int unsigned STROBE_NS = 30;
  localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  // register byte offsets
  localparam logic [3:0] OFS_BSW = 4'h0;
  localparam logic [3:0] OFS_AUX = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  // field positions
  localparam int unsigned AUX_XRAM_DIS = 0;
  localparam int unsigned AUX_SIXCLK = 1;
  localparam int unsigned STAT_SC0 = 0;
  localparam int unsigned STAT_SC1 = 1;
  localparam int unsigned STAT_RST = 2;
  // reset values
  localparam logic [1:0] BSW_RST = 2'h0;
  localparam logic [1:0] AUX_RST = 2'h0;
  // block switch settings
  localparam logic [1:0] BSW_OVERLAY = 2'h0;
  localparam logic [1:0] BSW_BOTH = 2'h1;
  // address map bounds
  localparam logic [15:0] OVL_TOP = 16'h1FFF;
  localparam logic [15:0] PRI_TOP = 16'h7FFF;
  localparam logic [15:0] SEC_BASE = 16'hE000;
  localparam logic [15:0] XRAM_TOP = 16'h02FF;
  localparam logic [7:0] LOW_TOP = 8'h7F;
  localparam logic [9:0] XRAM_BASE = 10'h100;
  localparam int unsigned RAM_BYTES = 1024;
  localparam int unsigned EXT_AW = 16;

  typedef enum logic [1:0] {
    RST_POR = 2'b00, RST_WDT = 2'b01, RST_BOD = 2'b10, RST_SW = 2'b11
  } mmd_rst_e;
  typedef enum logic [1:0] {
    F_NONE = 2'b00, F_PRI = 2'b01, F_SEC = 2'b10, F_EXT = 2'b11
  } mmd_fsel_e;
  typedef enum logic [2:0] {
    D_NONE = 3'b000, D_LOW = 3'b001, D_UPPER = 3'b010, D_SFR = 3'b011,
    D_XRAM = 3'b100, D_EXT = 3'b101
  } mmd_dtgt_e;
  typedef enum logic [1:0] {
    K_DIR = 2'b00, K_IND = 2'b01, K_XRI = 2'b10, K_XDP = 2'b11
  } mmd_dkind_e;
  typedef enum logic [1:0] {
    EX_IDLE = 2'b00, EX_ADDR = 2'b01, EX_STRB = 2'b10
  } mmd_ext_e;
endpackage : mmd_pkg

// [rtl/mmd_dacc_if.sv]
// data access request and decode result between top and decoder
// assumes the decoder answers combinationally
`timescale 1ns/1ps
interface mmd_dacc_if;
  import mmd_pkg::*;
  mmd_dkind_e kind;
  logic [15:0] addr;
  logic xram_dis;
  mmd_dtgt_e tgt;
  logic [9:0] idx;
  logic hi_drive;
  modport core (output kind, addr, xram_dis, input tgt, idx, hi_drive);
  modport dec (input kind, addr, xram_dis, output tgt, idx, hi_drive);
endinterface : mmd_dacc_if

// [rtl/mmd_data_decode.sv]
// internal data space decoder, purely combinational
// assumes the top samples its result on the request edge
`timescale 1ns/1ps
module mmd_data_decode
  import mmd_pkg::*;
(
  mmd_dacc_if.dec d
);
  logic [15:0] xa;

  // byte pointer moves only carry 8 address bits
  assign xa = (d.kind == K_XRI) ? {8'h00, d.addr[7:0]} : d.addr;

  // target selection by instruction kind and address
  always_comb begin
    d.tgt = D_NONE;
    d.idx = 10'h000;
    d.hi_drive = 1'b0;
    case (d.kind)
      K_DIR, K_IND: begin
        d.idx = {2'b00, d.addr[7:0]};
        if (d.addr[7:0] <= LOW_TOP) begin
          d.tgt = D_LOW;
        end else if (d.kind == K_IND) begin
          d.tgt = D_UPPER;
        end else begin
          d.tgt = D_SFR;
        end
      end
      K_XRI, K_XDP: begin
        if (!d.xram_dis && xa <= XRAM_TOP) begin
          d.tgt = D_XRAM;
          d.idx = 10'(XRAM_BASE + xa[9:0]);
        end else begin
          d.tgt = D_EXT;
          d.hi_drive = (d.kind == K_XDP);
        end
      end
      default: d.tgt = D_NONE;
    endcase
  end
endmodule : mmd_data_decode

// [rtl/mmd_reset_cfg.sv]
// block switch value to load for each kind of reset
// assumes start-up bits read 0 when programmed
`timescale 1ns/1ps
module mmd_reset_cfg
  import mmd_pkg::*;
(
  input mmd_rst_e kind_i,
  input logic sc1_i,
  input logic sc0_i,
  input logic [1:0] cur_i,
  output logic [1:0] bsw_o
);
  logic p1;
  logic p0;

  // programmed reads as zero, so invert to get "programmed"
  assign p1 = ~sc1_i;
  assign p0 = ~sc0_i;

  // per reset kind load table
  always_comb begin
    case (kind_i)
      RST_POR: bsw_o = {p1, p0};
      RST_WDT, RST_BOD: bsw_o = p1 ? {1'b1, p0} : {cur_i[1], p0};
      RST_SW: bsw_o = {1'b1, p0};
      default: bsw_o = {p1, p0};
    endcase
  end
endmodule : mmd_reset_cfg

// [bench/mmd_core_model.sv]
// core-side partner: issues program fetches and data accesses
// assumes its tasks are called just after a rising core clock edge
`timescale 1ns/1ps
module mmd_core_model
  import mmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  output logic fetch_req_o,
  output logic [15:0] fetch_addr_o,
  output logic dacc_req_o,
  output mmd_dkind_e dacc_kind_o,
  output logic [15:0] dacc_addr_o
);
  // idle core; it never switches blocks from low code
  initial begin
    fetch_req_o = 1'b0;
    fetch_addr_o = 16'h0000;
    dacc_req_o = 1'b0;
    dacc_kind_o = K_DIR;
    dacc_addr_o = 16'h0000;
  end

  // one fetch pulse; returns at the edge that takes it
  task automatic fetch(input logic [15:0] a);
    fetch_req_o <= 1'b1;
    fetch_addr_o <= a;
    @(posedge clk_i);
    fetch_req_o <= 1'b0;
    fetch_addr_o <= ~a; // stale address would hide a late sample
  endtask : fetch

  // request held until taken with ready; returns at the taking edge
  task automatic dacc(input mmd_dkind_e k, input logic [15:0] a);
    dacc_req_o <= 1'b1;
    dacc_kind_o <= k;
    dacc_addr_o <= a;
    #1;
    while (ready_i !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    dacc_req_o <= 1'b0;
    dacc_addr_o <= ~a;
  endtask : dacc
endmodule : mmd_core_model

// [bench/tb_mmd_top.sv]
// testbench of the memory map decoder: reset loading, block switching
// and data space decode; registers are reached over AXI4-Lite
// assumes the core model drives fetches and data accesses
`timescale 1ns/1ps
module tb_mmd_top;
  import mmd_pkg::*;
  logic clk, rstn, sc0, sc1, evt, freq, dreq, dhit, dready, edone, p0oe, rdn, wrn;
  logic awv, wv, bv, brdy, arv, rv, rrdy, awr, wr, arr, ireq, ivld, fvld;
  logic [3:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [7:0] p0, erd;
  logic [15:0] fa, da, foff, ia, ioff;
  logic [9:0] idx;
  mmd_rst_e kind;
  mmd_dkind_e dk;
  mmd_fsel_e fsel, isel;
  mmd_dtgt_e tgt;
  int errors, cmp_count;
  // warm reset table: {kind, sc1, sc0, expected field}
  localparam logic [5:0] WT [8] = '{6'b111110, 6'b011011, 6'b101110, 6'b001001,
    6'b000110, 6'b010011, 6'b111011, 6'b001100};

  mmd_top i_dut (.core_clk_i(clk), .rstn_i(rstn), .startup_cfg_bit0_i(sc0),
    .startup_cfg_bit1_i(sc1), .rst_evt_i(evt), .rst_kind_i(kind), .fetch_req_i(freq),
    .fetch_addr_i(fa), .fetch_vld_o(fvld), .fetch_sel_o(fsel), .fetch_off_o(foff),
    .iap_req_i(ireq), .iap_addr_i(ia), .iap_vld_o(ivld), .iap_sel_o(isel), .iap_off_o(ioff),
    .dacc_req_i(dreq), .dacc_kind_i(dk), .dacc_addr_i(da), .dacc_we_i(1'b0),
    .dacc_wdata_i(8'h00), .dacc_ready_o(dready), .dacc_hit_o(dhit), .dacc_tgt_o(tgt),
    .dacc_idx_o(idx), .ext_done_o(edone), .ext_rdata_o(erd), .p0_i(p0), .p0_o(),
    .p0_oe_o(p0oe), .p2_o(), .p2_oe_o(), .ale_o(), .wr_n_o(wrn), .rd_n_o(rdn),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy));
  mmd_core_model i_core (.clk_i(clk), .ready_i(dready), .fetch_req_o(freq),
    .fetch_addr_o(fa), .dacc_req_o(dreq), .dacc_kind_o(dk), .dacc_addr_o(da));

  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    #1;
    while (awv || wv) begin
      ta = awr;
      tw = wr;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      #1;
    end
    while (bv !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    chk("write response", 32'h0, {30'h0, br});
    @(posedge clk);
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta;
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    #1;
    while (arv) begin
      ta = arr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      #1;
    end
    while (rv !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    d = rd;
    r = rr;
    @(posedge clk);
  endtask : axr

  task automatic warm(input logic [5:0] w);
    {sc1, sc0} <= w[3:2];
    kind <= mmd_rst_e'(w[5:4]);
    evt <= 1'b1;
    @(posedge clk);
    evt <= 1'b0;
  endtask : warm

  task automatic t_warm();
    logic [31:0] d;
    logic [1:0] r;
    axr(OFS_BSW, d, r);
    chk("power-on field", 32'h0, {30'h0, d[1:0]});
    axr(4'hC, d, r);
    chk("unmapped response", 32'h2, {30'h0, r});
    foreach (WT[i]) begin
      warm(WT[i]);
      axr(OFS_BSW, d, r);
      chk("reset field", {30'h0, WT[i][1:0]}, {30'h0, d[1:0]});
      axr(OFS_STAT, d, r);
      chk("start-up bits", {30'h0, WT[i][3:2]}, {30'h0, d[STAT_SC1], d[STAT_SC0]});
    end
    $display("test warm reset load done");
  endtask : t_warm

  task automatic fchk(input logic [15:0] a, input mmd_fsel_e s, input logic [15:0] o);
    i_core.fetch(a);
    #1;
    chk("fetch valid", 32'h1, {31'h0, fvld});
    chk("fetch block", {30'h0, s}, {30'h0, fsel});
    chk("fetch offset", {16'h0, o}, {16'h0, foff});
    @(posedge clk);
  endtask : fchk

  // programming path: one request pulse, result checked while valid stands
  task automatic ichk(input logic [15:0] a, input mmd_fsel_e s, input logic [15:0] o);
    ireq <= 1'b1;
    ia <= a;
    @(posedge clk);
    ireq <= 1'b0;
    #1;
    chk("iap valid", 32'h1, {31'h0, ivld});
    chk("iap block", {30'h0, s}, {30'h0, isel});
    chk("iap offset", {16'h0, o}, {16'h0, ioff});
    @(posedge clk);
  endtask : ichk

  task automatic t_fetch();
    logic [31:0] d;
    logic [1:0] r;
    fchk(16'h1FFF, F_SEC, 16'h1FFF);
    fchk(16'h2000, F_PRI, 16'h2000);
    ichk(16'h1FFF, F_PRI, 16'h1FFF);
    ichk(16'h9000, F_NONE, 16'h9000);
    axw(OFS_BSW, 32'h0000_0003); // bit 1 must stay put
    axr(OFS_BSW, d, r);
    chk("written field", 32'h1, {30'h0, d[1:0]});
    axr(OFS_STAT, d, r);
    chk("start-up bit0 kept", 32'h1, {31'h0, d[STAT_SC0]});
    fchk(16'h1000, F_PRI, 16'h1000);
    fchk(16'hE004, F_SEC, 16'h0004);
    warm(WT[0]);
    fchk(16'hE004, F_EXT, 16'hE004);
    ichk(16'hE004, F_SEC, 16'h0004);
    $display("test block switching done");
  endtask : t_fetch

  task automatic dchk(input mmd_dkind_e k, input logic [15:0] a, input mmd_dtgt_e t,
    input logic [9:0] x);
    i_core.dacc(k, a);
    #1;
    chk("hit", 32'h1, {31'h0, dhit});
    chk("target", {29'h0, t}, {29'h0, tgt});
    if (t != D_SFR) chk("index", {22'h0, x}, {22'h0, idx});
    chk("bus still", 32'h3, {29'h0, p0oe, rdn, wrn});
    @(posedge clk);
  endtask : dchk

  task automatic echk(input mmd_dkind_e k, input logic [15:0] a);
    int n;
    n = 0;
    p0 <= a[7:0] ^ 8'h5A; // fresh port value per cycle
    i_core.dacc(k, a);
    #1;
    while (edone !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("external cycles", 32'(1 + STROBE_CYC), n);
    chk("external data", {24'h0, p0}, {24'h0, erd});
    @(posedge clk);
  endtask : echk

  task automatic t_data();
    dchk(K_DIR, 16'h0010, D_LOW, 10'h010);
    dchk(K_IND, 16'h0010, D_LOW, 10'h010);
    dchk(K_DIR, 16'h0090, D_SFR, 10'h090);
    dchk(K_IND, 16'h0090, D_UPPER, 10'h090);
    dchk(K_XDP, 16'h02FF, D_XRAM, 10'h3FF);
    dchk(K_XRI, 16'h002F, D_XRAM, 10'h12F);
    echk(K_XDP, 16'h0300);
    axw(OFS_AUX, 32'h0000_0003); // expanded RAM off, 6-clock strobe
    echk(K_XRI, 16'h0040);
    $display("test data decode done");
  endtask : t_data

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // hang guard, far beyond the hundred or so cycles the tests need
  initial begin
    #40000;
    errors++;
    print_verdict();
  end

  initial begin
    {errors, cmp_count} = '0;
    {rstn, evt, awv, wv, brdy, arv, rrdy, ireq} = '0;
    {sc1, sc0} = 2'h3;
    kind = RST_POR;
    p0 = 8'hC3;
    {awa, ara, wd, ia} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_warm();
    t_fetch();
    t_data();
    print_verdict();
  end
endmodule : tb_mmd_top
